// file: design/ext_irq_pkg.sv
// Constants shared by the external pin interrupt control block
`default_nettype none
package ext_irq_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_EDGE = 4'h1;
  localparam logic [3:0] OFF_STAT = 4'h2;
  localparam logic [3:0] OFF_MASK = 4'h3;

  // Field positions in external_pin_irq_control
  localparam int BIT_SRC2_PRIORITY = 7;
  localparam int BIT_SRC1_PRIORITY = 6;
  localparam int BIT_SRC2_ENABLE = 4;
  localparam int BIT_SRC1_ENABLE = 3;
  localparam int BIT_SRC2_FLAG = 1;
  localparam int BIT_SRC1_FLAG = 0;

  // Positions in the edge, status and mask registers
  localparam int BIT_SRC1 = 0;
  localparam int BIT_SRC2 = 1;

  // Values after reset and implemented-bit masks
  localparam logic [7:0] CTRL_RST = 8'hC0;
  localparam logic [7:0] CTRL_IMPL = 8'hDB;
  localparam logic [7:0] EDGE_RST = 8'h03;
  localparam logic [7:0] EDGE_IMPL = 8'h03;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MASK_IMPL = 8'h03;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Register port access kinds
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'b001,
    ACC_WRITE = 3'b010,
    ACC_READ  = 3'b100
  } access_t;
endpackage
`default_nettype wire

// file: design/pin_edge_sync.sv
// Pin synchroniser and selectable edge detector for one interrupt source
`default_nettype none
module pin_edge_sync
  import ext_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and edge choice
  input wire logic pin,
  input wire logic rise_sel,
  // Event
  output logic edge_pulse
);
  logic meta_ff, sync_ff, prev_ff;
  logic nxt_meta, nxt_sync, nxt_prev;

  always_comb begin
    nxt_meta = pin;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // Reset to low so a pin held high at release reads as a rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // Only the second and third stages feed the edge logic
  assign edge_pulse = rise_sel ? (sync_ff & ~prev_ff) : (~sync_ff & prev_ff);
endmodule
`default_nettype wire

// file: design/ext_irq_ctrl.sv
// External pin interrupt control and status block with register port
//
// Functional notes
// - Priority bits 7 and 6, R/W, reset one.
// - Priority one goes high level, zero low.
// - Pin event sets flag; only software clears.
// - Flag sets regardless of any enable.
// - Flags readable anytime for polling.
// - Bits 5 and 2 read zero, ignore writes.
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module ext_irq_ctrl
  import ext_irq_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // External interrupt pins
  input wire logic SRC1_PIN,
  input wire logic SRC2_PIN,
  // Core side
  input wire logic GLOBAL_EN,
  output logic IRQ_HIGH,
  output logic IRQ_LOW,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // Event interrupt
  output logic IRQ
);

  // Offsets need two address bits; every field assumes one byte
  if (ADDR_W < 2 || DATA_W != 8) begin : g_bad_params
    $error("ext_irq_ctrl: ADDR_W must be >= 2 and DATA_W must be 8");
  end

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] edge_ff, nxt_edge;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_high_ff, nxt_irq_high;
  logic irq_low_ff, nxt_irq_low;
  logic irq_ff, nxt_irq;
  logic ev1, ev2;
  logic sel_ctrl, sel_edge, sel_stat, sel_mask;
  logic req1, req2;
  access_t acc;

  // Pin events
  pin_edge_sync u_sync1 (
    .clk(CLK),
    .rst(RST),
    .pin(SRC1_PIN),
    .rise_sel(edge_ff[BIT_SRC1]),
    .edge_pulse(ev1)
  );

  pin_edge_sync u_sync2 (
    .clk(CLK),
    .rst(RST),
    .pin(SRC2_PIN),
    .rise_sel(edge_ff[BIT_SRC2]),
    .edge_pulse(ev2)
  );

  // Address decode
  always_comb begin
    sel_ctrl = 1'b0;
    sel_edge = 1'b0;
    sel_stat = 1'b0;
    sel_mask = 1'b0;
    if (ADDR == ADDR_W'(OFF_CTRL)) begin
      sel_ctrl = 1'b1;
    end else if (ADDR == ADDR_W'(OFF_EDGE)) begin
      sel_edge = 1'b1;
    end else if (ADDR == ADDR_W'(OFF_STAT)) begin
      sel_stat = 1'b1;
    end else if (ADDR == ADDR_W'(OFF_MASK)) begin
      sel_mask = 1'b1;
    end
  end

  always_comb begin
    if (WR) begin
      acc = ACC_WRITE;
    end else if (RD) begin
      acc = ACC_READ;
    end else begin
      acc = ACC_IDLE;
    end
  end

  // Register file next state
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_edge = edge_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_rdata = RDATA_RST;
    case (acc)
      ACC_WRITE: begin
        if (sel_ctrl) begin
          nxt_ctrl = WDATA & CTRL_IMPL;
        end
        if (sel_edge) begin
          nxt_edge = WDATA & EDGE_IMPL;
        end
        if (sel_mask) begin
          nxt_mask = WDATA & MASK_IMPL;
        end
      end
      ACC_READ: begin
        if (sel_ctrl) begin
          nxt_rdata = ctrl_ff & CTRL_IMPL;
        end else if (sel_edge) begin
          nxt_rdata = edge_ff;
        end else if (sel_stat) begin
          nxt_rdata = stat_ff;
          nxt_stat = STAT_RST;
        end else if (sel_mask) begin
          nxt_rdata = mask_ff;
        end
      end
      default: begin
        nxt_rdata = RDATA_RST;
      end
    endcase
    // Events win over a software clear in the same cycle
    if (ev1) begin
      nxt_ctrl[BIT_SRC1_FLAG] = 1'b1;
      nxt_stat[BIT_SRC1] = 1'b1;
    end
    if (ev2) begin
      nxt_ctrl[BIT_SRC2_FLAG] = 1'b1;
      nxt_stat[BIT_SRC2] = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= CTRL_RST;
      edge_ff <= EDGE_RST;
      stat_ff <= STAT_RST;
      mask_ff <= MASK_RST;
      rdata_ff <= RDATA_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      edge_ff <= nxt_edge;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  // Request routing to the core
  always_comb begin
    req1 = ctrl_ff[BIT_SRC1_FLAG] & ctrl_ff[BIT_SRC1_ENABLE];
    req2 = ctrl_ff[BIT_SRC2_FLAG] & ctrl_ff[BIT_SRC2_ENABLE];
    nxt_irq_high = GLOBAL_EN & ((req1 & ctrl_ff[BIT_SRC1_PRIORITY]) |
                                (req2 & ctrl_ff[BIT_SRC2_PRIORITY]));
    nxt_irq_low = GLOBAL_EN & ((req1 & ~ctrl_ff[BIT_SRC1_PRIORITY]) |
                               (req2 & ~ctrl_ff[BIT_SRC2_PRIORITY]));
    nxt_irq = |(stat_ff & mask_ff);
  end

  // One cycle of latency is traded for glitch-free outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_high_ff <= 1'b0;
      irq_low_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_high_ff <= nxt_irq_high;
      irq_low_ff <= nxt_irq_low;
      irq_ff <= nxt_irq;
    end
  end

  assign IRQ_HIGH = irq_high_ff;
  assign IRQ_LOW = irq_low_ff;
  assign IRQ = irq_ff;
  assign RDATA = rdata_ff;

  // Checks
  logic first_done_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      first_done_ff <= 1'b0;
    end else begin
      first_done_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence seq_wr_ctrl;
    WR && (ADDR == ADDR_W'(OFF_CTRL));
  endsequence

  sequence seq_rd_ctrl;
    RD && !WR && (ADDR == ADDR_W'(OFF_CTRL));
  endsequence

  sequence seq_req1_high;
    GLOBAL_EN && req1 && ctrl_ff[BIT_SRC1_PRIORITY];
  endsequence

  sequence seq_req1_low;
    GLOBAL_EN && req1 && !ctrl_ff[BIT_SRC1_PRIORITY];
  endsequence

  sequence seq_req2_high;
    GLOBAL_EN && req2 && ctrl_ff[BIT_SRC2_PRIORITY];
  endsequence

  sequence seq_req2_low;
    GLOBAL_EN && req2 && !ctrl_ff[BIT_SRC2_PRIORITY];
  endsequence

  AST_PRIO_RESET: assert property (
    !first_done_ff |-> (ctrl_ff[7:6] == 2'b11) && (ctrl_ff[4:3] == 2'b00))
    else $error("priority or enable bits wrong after reset");

  AST_PRIO_WRITE: assert property (
    seq_wr_ctrl |=> ctrl_ff[7:6] == $past(WDATA[7:6]))
    else $error("priority bits did not take written value");

  AST_ROUTE_HIGH: assert property (
    seq_req1_high |=> IRQ_HIGH)
    else $error("high priority request not routed high");

  AST_ROUTE_LOW: assert property (
    seq_req1_low ##0 (!req2 || !ctrl_ff[BIT_SRC2_PRIORITY]) |=> IRQ_LOW && !IRQ_HIGH)
    else $error("low priority request not routed low");

  AST_FLAG_STICKY: assert property (
    ctrl_ff[BIT_SRC1_FLAG] && !(WR && (ADDR == ADDR_W'(OFF_CTRL))) |=> ctrl_ff[BIT_SRC1_FLAG])
    else $error("flag cleared without software write");

  AST_FLAG_SET_ANY: assert property (
    ev2 && !ctrl_ff[BIT_SRC2_ENABLE] |=> ctrl_ff[BIT_SRC2_FLAG] ##1 1'b1)
    else $error("event did not set flag while disabled");

  AST_POLL_READ: assert property (
    seq_rd_ctrl |=> RDATA[1:0] == $past(ctrl_ff[1:0]))
    else $error("flag read back wrong");

  AST_RESVD_ZERO: assert property (
    seq_wr_ctrl ##[1:2] seq_rd_ctrl |=> (RDATA[5] == 1'b0) && (RDATA[2] == 1'b0))
    else $error("unimplemented bits not zero");

  AST_REQ_NEEDS_EN: assert property (
    (IRQ_HIGH || IRQ_LOW) |-> $past(req1) || $past(req2))
    else $error("request without flag and enable");

  AST_ROUTE_HIGH2: assert property (
    seq_req2_high |=> IRQ_HIGH)
    else $error("second source high request not routed high");

  AST_ROUTE_LOW2: assert property (
    seq_req2_low ##0 (!req1 || !ctrl_ff[BIT_SRC1_PRIORITY]) |=> IRQ_LOW && !IRQ_HIGH)
    else $error("second source low request not routed low");

  AST_FLAG2_STICKY: assert property (
    ctrl_ff[BIT_SRC2_FLAG] && !(WR && (ADDR == ADDR_W'(OFF_CTRL))) |=> ctrl_ff[BIT_SRC2_FLAG])
    else $error("second flag cleared without software write");

  AST_FLAG1_SET: assert property (
    ev1 |=> ctrl_ff[BIT_SRC1_FLAG])
    else $error("first source event did not set its flag");

  AST_FLAG2_SET: assert property (
    ev2 |=> ctrl_ff[BIT_SRC2_FLAG])
    else $error("second source event did not set its flag");

  AST_FLAG_SET_GIE_OFF: assert property (
    ev1 && !GLOBAL_EN |=> ctrl_ff[BIT_SRC1_FLAG])
    else $error("event did not set flag with core enable off");

  AST_PRIO_HELD: assert property (
    !(WR && (ADDR == ADDR_W'(OFF_CTRL))) |=> $stable(ctrl_ff[7:6]))
    else $error("priority bits changed without a write");

  AST_RESVD_HELD: assert property (
    !ctrl_ff[5] && !ctrl_ff[2])
    else $error("unimplemented control bits set");

  AST_RDATA_IDLE: assert property (
    (!RD || WR) |=> RDATA == '0)
    else $error("read data outside the read answer cycle");

  AST_GIE_OFF_QUIET: assert property (
    !GLOBAL_EN |=> !IRQ_HIGH && !IRQ_LOW)
    else $error("request raised with core enable off");

endmodule
`default_nettype wire

// file: testbench/ext_side_model.sv
// Model of the external pins and the core enable facing the block
`default_nettype none
module ext_side_model (
  // Clock
  input wire logic clk,
  // Requests from the test sequence
  input wire logic [1:0] pin_req,
  input wire logic gie_req,
  // Pins and core enable
  output logic src1_pin,
  output logic src2_pin,
  output logic global_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // Levels follow the sequence one edge late; unknown only while reset holds
  // Changes land just after an edge, as a clean pin driver would
  always @(posedge clk) begin
    src1_pin <= pin_req[0];
    src2_pin <= pin_req[1];
    global_en <= gie_req;
  end
endmodule
`default_nettype wire

// file: testbench/ext_irq_ctrl_tb.sv
// Self-checking bench for the external pin interrupt control block
`default_nettype none
module ext_irq_ctrl_tb
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] pin_req = 2'b00;
  logic gie_req = 1'b0;
  logic src1_pin, src2_pin, global_en;
  logic irq_high, irq_low, irq;
  logic [7:0] rdata;
  int n_fail = 0;
  int n_tests = 0;
  logic [7:0] fl, en, pr;

  always #50 clk = ~clk;

  ext_side_model i_ext_side_model (.clk(clk), .pin_req(pin_req), .gie_req(gie_req),
    .src1_pin(src1_pin), .src2_pin(src2_pin), .global_en(global_en));

  ext_irq_ctrl i_ext_irq_ctrl (.CLK(clk), .RST(rst), .SRC1_PIN(src1_pin), .SRC2_PIN(src2_pin),
    .GLOBAL_EN(global_en), .IRQ_HIGH(irq_high), .IRQ_LOW(irq_low), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // Requests are registered behind the core enable, so allow settling
  task automatic chk_out(input logic hi, input logic lo);
    repeat (3) @(posedge clk);
    #1;
    check({7'h00, irq_high}, {7'h00, hi});
    check({7'h00, irq_low}, {7'h00, lo});
  endtask

  // Rising pin then back low; falling edge is not selected
  task automatic pin_event(input int s);
    @(posedge clk);
    pin_req[s] <= 1'b1;
    repeat (8) @(posedge clk);
    pin_req[s] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic set_gie(input logic v);
    @(posedge clk);
    gie_req <= v;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFF_CTRL, 8'hC0);
    rd_reg(OFF_STAT, 8'h00);
    rd_reg(OFF_MASK, 8'h00);
    rd_reg(OFF_EDGE, 8'h03);
    wr_reg(OFF_CTRL, 8'hFF);
    rd_reg(OFF_CTRL, 8'hDB);
    wr_reg(OFF_CTRL, 8'h24);
    rd_reg(OFF_CTRL, 8'h00);
    wr_reg(4'h5, 8'hFF);
    rd_reg(4'h5, 8'h00);
    wr_reg(OFF_MASK, 8'h03);
    for (int s = 0; s < 2; s++) begin
      fl = 8'h01 << s;
      en = 8'h08 << s;
      pr = 8'h40 << s;
      // Event with source and core enables off still sets the flag
      pin_event(s);
      rd_reg(OFF_CTRL, fl);
      chk_out(1'b0, 1'b0);
      check({7'h00, irq}, 8'h01);
      rd_reg(OFF_STAT, fl);
      rd_reg(OFF_STAT, 8'h00);
      check({7'h00, irq}, 8'h00);
      rd_reg(OFF_CTRL, fl);
      wr_reg(OFF_CTRL, 8'h00);
      set_gie(1'b1);
      wr_reg(OFF_CTRL, en | pr);
      chk_out(1'b0, 1'b0);
      pin_event(s);
      chk_out(1'b1, 1'b0);
      wr_reg(OFF_CTRL, en | fl);
      chk_out(1'b0, 1'b1);
      set_gie(1'b0);
      chk_out(1'b0, 1'b0);
      set_gie(1'b1);
      chk_out(1'b0, 1'b1);
      wr_reg(OFF_CTRL, en);
      chk_out(1'b0, 1'b0);
      rd_reg(OFF_STAT, fl);
      set_gie(1'b0);
      wr_reg(OFF_CTRL, 8'h00);
    end
    // Falling edge for source 1: a rise alone must leave the flag clear
    wr_reg(OFF_EDGE, 8'h02);
    rd_reg(OFF_EDGE, 8'h02);
    @(posedge clk);
    pin_req <= 2'b01;
    repeat (6) @(posedge clk);
    rd_reg(OFF_CTRL, 8'h00);
    @(posedge clk);
    pin_req <= 2'b00;
    repeat (6) @(posedge clk);
    rd_reg(OFF_CTRL, 8'h01);
    rd_reg(OFF_STAT, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
